/* File: cli_detector.sv */
// Purpose: Cold load pick-up and magnetising inrush detector with AXI4-Lite registers.
// Assumes: Measurement inputs come from logic on ref_clk; meas_valid pulses per update.
// Notes: Idle and pickup thresholds compare the largest phase magnitude; timing in whole milliseconds.
//
// Register access over AXI4-Lite and the address map were decided locally.
module cli_detector #(
  parameter int MS_CYCLES = cli_pkg::CLI_MS_CYCLES
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  // Measurements
  input  wire logic                 meas_valid,
  input  wire cli_pkg::cli_phases_t phases,
  input  wire cli_pkg::cli_ratios_t ratios,
  // AXI4-Lite write
  input  wire logic [7:0]           s_awaddr,
  input  wire logic                 s_awvalid,
  output logic                      s_awready,
  input  wire logic [31:0]          s_wdata,
  input  wire logic [3:0]           s_wstrb,
  input  wire logic                 s_wvalid,
  output logic                      s_wready,
  output logic [1:0]                s_bresp,
  output logic                      s_bvalid,
  input  wire logic                 s_bready,
  // AXI4-Lite read
  input  wire logic [7:0]           s_araddr,
  input  wire logic                 s_arvalid,
  output logic                      s_arready,
  output logic [31:0]               s_rdata,
  output logic [1:0]                s_rresp,
  output logic                      s_rvalid,
  input  wire logic                 s_rready,
  // Matrix sources and interrupt
  output logic                      cold_load_det,
  output logic                      inrush_det,
  output logic                      irq
);
  import cli_pkg::*;
  if (MS_CYCLES < 2) begin : g_bad_ms
    $error("cli_detector: MS_CYCLES too small");
  end

  // ----------------------------------------
  // Settings and registers
  // ----------------------------------------
  cli_settings_t set_r;
  logic [15:0]   mode_i_r;
  logic          pwd_ok_r;
  logic [CLI_IRQ_W-1:0] irq_stat_r, irq_en_r;

  logic [15:0] imax;
  logic        f2_any;
  logic        ms_tick;

  cli_max3 u_max (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .phases  (phases),
    .ratios  (ratios),
    .f2_thr  (set_r.second_harmonic_threshold),
    .imax    (imax),
    .f2_any  (f2_any)
  );

  cli_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick    (ms_tick)
  );

  // ----------------------------------------
  // Level classification
  // ----------------------------------------
  wire below_idle  = imax < set_r.idle_lvl;
  wire above_pick  = imax > set_r.pickup_lvl;
  wire f2_disabled = set_r.second_harmonic_threshold == 8'h00;

  typedef enum logic [1:0] { CLI_ARM_WAIT, CLI_ARM_IDLE, CLI_ARM_RISE, CLI_ARM_LATE } cli_arm_t;
  cli_arm_t    arm_r;
  logic [15:0] rise_ms_r;
  logic        start_ev;

  // Start only from idle, and only if pickup is reached within 80 ms
  assign start_ev = meas_valid && above_pick &&
                    (arm_r == CLI_ARM_IDLE || arm_r == CLI_ARM_RISE);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      arm_r     <= CLI_ARM_WAIT;
      rise_ms_r <= 16'h0000;
    end else if (meas_valid && below_idle) begin
      arm_r     <= CLI_ARM_IDLE;
      rise_ms_r <= 16'h0000;
    end else begin
      case (arm_r)
        CLI_ARM_IDLE: begin
          if (start_ev) arm_r <= CLI_ARM_WAIT;
          else if (meas_valid) arm_r <= CLI_ARM_RISE;
        end
        CLI_ARM_RISE: begin
          if (start_ev) arm_r <= CLI_ARM_WAIT;
          else if (ms_tick) begin
            rise_ms_r <= rise_ms_r + 16'h0001;
            if (rise_ms_r >= 16'(CLI_TRANSITION_MS - 1)) arm_r <= CLI_ARM_LATE;
          end
        end
        CLI_ARM_LATE: arm_r <= CLI_ARM_LATE;
        default:      arm_r <= CLI_ARM_WAIT;
      endcase
    end
  end

  // ----------------------------------------
  // Detection timers
  // ----------------------------------------
  logic [15:0] hold_cnt_r;
  logic [15:0] cyc_cnt_r;
  logic        cl_act_r, in_act_r, in_confirm_r;
  cli_status_t cl_stat_r, in_stat_r;

  // Timers move on the ms tick, so each bound has up to one ms of slack
  wire hold_done = (hold_cnt_r == 16'h0000);
  wire cl_keep   = !hold_done || above_pick;
  wire in_keep   = cl_keep && (f2_disabled || !in_confirm_r || f2_any);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_cnt_r   <= 16'h0000;
      cyc_cnt_r    <= 16'h0000;
      cl_act_r     <= 1'b0;
      in_act_r     <= 1'b0;
      in_confirm_r <= 1'b0;
      cl_stat_r    <= CLI_ST_INACTIVE;
      in_stat_r    <= CLI_ST_INACTIVE;
    end else if (start_ev && !cl_act_r) begin
      hold_cnt_r   <= set_r.hold_ms;
      cyc_cnt_r    <= 16'(CLI_FIRST_CYCLE_MS);
      cl_act_r     <= 1'b1;
      in_act_r     <= 1'b1;
      in_confirm_r <= 1'b0;
      cl_stat_r    <= CLI_ST_START;
      in_stat_r    <= CLI_ST_START;
    end else begin
      if (ms_tick && !hold_done) hold_cnt_r <= hold_cnt_r - 16'h0001;
      if (ms_tick && cyc_cnt_r != 16'h0000) cyc_cnt_r <= cyc_cnt_r - 16'h0001;
      if (cyc_cnt_r == 16'h0000) in_confirm_r <= 1'b1;
      if (cl_act_r && !cl_keep) begin
        cl_act_r  <= 1'b0;
        cl_stat_r <= CLI_ST_TRIP;
      end
      if (in_act_r && !in_keep) begin
        in_act_r  <= 1'b0;
        in_stat_r <= CLI_ST_TRIP;
      end else if (f2_disabled && cl_act_r && cl_keep && !in_act_r) begin
        // Zero threshold set mid-event rejoins inrush to cold load
        in_act_r  <= 1'b1;
        in_stat_r <= CLI_ST_START;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cold_load_det <= 1'b0;
      inrush_det    <= 1'b0;
    end else begin
      cold_load_det <= cl_act_r;
      inrush_det    <= in_act_r;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  wire [CLI_IRQ_W-1:0] irq_ev = {in_act_r && !in_keep, cl_act_r && !cl_keep,
                                 start_ev && !cl_act_r && !f2_disabled, start_ev && !cl_act_r};

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  // One write in flight; readies stay low until the response is taken
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic        aw_have_r, w_have_r;
  wire         wr_go   = aw_have_r && w_have_r && !s_bvalid;
  wire [7:0]   wa      = aw_addr_r;
  wire         set_ok  = wr_go && pwd_ok_r;
  wire         known_w = wa == CLI_OFF_CTRL || wa == CLI_OFF_HOLD || wa == CLI_OFF_IDLE ||
                         wa == CLI_OFF_PICKUP || wa == CLI_OFF_F2 || wa == CLI_OFF_IRQ_EN ||
                         wa == CLI_OFF_IRQ_CLR || wa == CLI_OFF_MODE_I;
  wire [CLI_IRQ_W-1:0] irq_clr = (wr_go && wa == CLI_OFF_IRQ_CLR) ? w_data_r[CLI_IRQ_W-1:0] : '0;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h00000000;
      s_awready <= 1'b1;
      s_wready  <= 1'b1;
      s_bvalid  <= 1'b0;
      s_bresp   <= 2'h0;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_addr_r <= s_awaddr;
        aw_have_r <= 1'b1;
        s_awready <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_data_r <= s_wdata;
        w_have_r <= 1'b1;
        s_wready <= 1'b0;
      end
      if (wr_go) begin
        s_bvalid  <= 1'b1;
        s_bresp   <= known_w ? 2'h0 : 2'h2;
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end
      if (s_bvalid && s_bready) begin
        s_bvalid  <= 1'b0;
        s_awready <= 1'b1;
        s_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      set_r      <= '{CLI_RST_HOLD, CLI_RST_IDLE, CLI_RST_PICKUP, CLI_RST_F2};
      mode_i_r   <= CLI_RST_MODE_I;
      pwd_ok_r   <= 1'b0;
      irq_en_r   <= '0;
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_ev; // Set wins over clear
      if (wr_go && wa == CLI_OFF_CTRL) pwd_ok_r <= (w_data_r == CLI_PWD_KEY);
      if (wr_go && wa == CLI_OFF_IRQ_EN) irq_en_r <= w_data_r[CLI_IRQ_W-1:0];
      if (set_ok && wa == CLI_OFF_HOLD) set_r.hold_ms <= w_data_r[15:0];
      if (set_ok && wa == CLI_OFF_IDLE) set_r.idle_lvl <= w_data_r[15:0];
      if (set_ok && wa == CLI_OFF_PICKUP) set_r.pickup_lvl <= w_data_r[15:0];
      if (set_ok && wa == CLI_OFF_F2) set_r.second_harmonic_threshold <= w_data_r[7:0];
      if (set_ok && wa == CLI_OFF_MODE_I) mode_i_r <= w_data_r[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) irq <= 1'b0;
    else         irq <= |(irq_stat_r & irq_en_r);
  end

  // Primary scaled values; products kept 32 bits wide
  wire [31:0] idle_pri = (32'(set_r.idle_lvl) * 32'(mode_i_r)) >> CLI_SCALE_SHIFT;
  wire [31:0] pick_pri = (32'(set_r.pickup_lvl) * 32'(mode_i_r)) >> CLI_SCALE_SHIFT;

  wire [7:0]  ra = s_araddr;
  wire [31:0] rd_mux =
    (ra == CLI_OFF_CTRL)     ? {31'h0, pwd_ok_r} :
    (ra == CLI_OFF_HOLD)     ? {16'h0, set_r.hold_ms} :
    (ra == CLI_OFF_IDLE)     ? {16'h0, set_r.idle_lvl} :
    (ra == CLI_OFF_PICKUP)   ? {16'h0, set_r.pickup_lvl} :
    (ra == CLI_OFF_F2)       ? {24'h0, set_r.second_harmonic_threshold} :
    (ra == CLI_OFF_STATUS)   ? {28'h0, in_stat_r, cl_stat_r} :
    (ra == CLI_OFF_IMAX)     ? {16'h0, imax} :
    (ra == CLI_OFF_IDLE_PRI) ? idle_pri :
    (ra == CLI_OFF_PICK_PRI) ? pick_pri :
    (ra == CLI_OFF_IRQ_STAT) ? {28'h0, irq_stat_r} :
    (ra == CLI_OFF_IRQ_EN)   ? {28'h0, irq_en_r} :
    (ra == CLI_OFF_MODE_I)   ? {16'h0, mode_i_r} : 32'h00000000;
  wire rd_known = (ra <= CLI_OFF_MODE_I) && (ra[1:0] == 2'h0) && (ra != CLI_OFF_IRQ_CLR);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_arready <= 1'b1;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h00000000;
      s_rresp   <= 2'h0;
    end else if (s_arvalid && s_arready) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b1;
      s_rdata   <= rd_mux;
      s_rresp   <= rd_known ? 2'h0 : 2'h2;
    end else if (s_rvalid && s_rready) begin
      s_rvalid  <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_rise_from_idle;
    meas_valid && below_idle ##1 (!below_idle)[*1];
  endsequence

  sequence s_cold_start;
    start_ev && !cl_act_r;
  endsequence

  a_start_needs_arm: assert property (@(posedge ref_clk) disable iff (!resetn)
    start_ev |-> arm_r != CLI_ARM_WAIT && arm_r != CLI_ARM_LATE) else $error("start without idle");
  a_late_blocks: assert property (@(posedge ref_clk) disable iff (!resetn)
    arm_r == CLI_ARM_LATE |-> !start_ev) else $error("late rise started");
  a_cl_follows: assert property (@(posedge ref_clk) disable iff (!resetn)
    start_ev && !cl_act_r |=> cl_act_r ##1 cold_load_det) else $error("cold load missed");
  a_hold_loaded: assert property (@(posedge ref_clk) disable iff (!resetn)
    start_ev && !cl_act_r |=> hold_cnt_r == $past(set_r.hold_ms)) else $error("hold not loaded");
  a_cl_keeps: assert property (@(posedge ref_clk) disable iff (!resetn)
    cl_act_r && !start_ev && cl_keep |=> cl_act_r) else $error("early release");
  a_cl_trip_stat: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(cl_act_r) |-> cl_stat_r == CLI_ST_TRIP) else $error("status not trip");
  a_in_stat: assert property (@(posedge ref_clk) disable iff (!resetn)
    in_act_r |-> in_stat_r == CLI_ST_START) else $error("inrush status");
  a_in_equal: assert property (@(posedge ref_clk) disable iff (!resetn)
    f2_disabled && $stable(f2_disabled) && cl_act_r |-> in_act_r == cl_act_r) else $error("inrush differs");
  a_in_within_cl: assert property (@(posedge ref_clk) disable iff (!resetn)
    in_act_r |-> cl_act_r) else $error("inrush without cold load");
  a_pwd_guard: assert property (@(posedge ref_clk) disable iff (!resetn)
    !pwd_ok_r |=> $stable(set_r)) else $error("setting written locked");
  a_rearm_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_rise_from_idle |-> arm_r != CLI_ARM_WAIT) else $error("not armed after idle");
  a_cl_release: assert property (@(posedge ref_clk) disable iff (!resetn)
    cl_act_r && hold_done && !above_pick |=> !cl_act_r) else $error("cold load held too long");
  a_cl_stat_start: assert property (@(posedge ref_clk) disable iff (!resetn)
    cl_act_r |-> cl_stat_r == CLI_ST_START) else $error("cold status not start");
  a_in_first: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_cold_start |=> in_act_r && !in_confirm_r) else $error("inrush not started");
  a_in_drop: assert property (@(posedge ref_clk) disable iff (!resetn)
    in_act_r && in_confirm_r && !f2_any && !f2_disabled |=> !in_act_r) else $error("inrush kept");
  a_in_trip_stat: assert property (@(posedge ref_clk) disable iff (!resetn)
    $fell(in_act_r) |-> in_stat_r == CLI_ST_TRIP) else $error("inrush status not trip");
  a_rise_window: assert property (@(posedge ref_clk) disable iff (!resetn)
    arm_r == CLI_ARM_RISE |-> rise_ms_r < 16'(CLI_TRANSITION_MS)) else $error("rise window overrun");
  a_det_mirror: assert property (@(posedge ref_clk) disable iff (!resetn)
    cold_load_det == $past(cl_act_r) && inrush_det == $past(in_act_r)) else $error("matrix source lag");
  a_pwd_key: assert property (@(posedge ref_clk) disable iff (!resetn)
    wr_go && wa == CLI_OFF_CTRL |=> pwd_ok_r == ($past(w_data_r) == CLI_PWD_KEY)) else $error("password state");
  a_irq_level: assert property (@(posedge ref_clk) disable iff (!resetn)
    irq == $past(|(irq_stat_r & irq_en_r))) else $error("irq level wrong");
  a_aw_blocked: assert property (@(posedge ref_clk) disable iff (!resetn)
    aw_have_r |-> !s_awready) else $error("address ready while busy");
  a_rd_slverr: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_arvalid && s_arready && !rd_known |=> s_rresp == 2'h2) else $error("unmapped read not refused");
endmodule : cli_detector

/* File: cli_pkg.sv */
// Purpose: Constants and types for the cold load and inrush detector.
// Assumes: 100 MHz ref_clk; measurement updates arrive as one-cycle strobes.
// Notes on behaviour
// - Cold load: all phases below idle, then one above pickup within 80 ms.
// - Cold load declaration asserts the detection output for the hold time.
// - Output stays while hold time runs or current stays above pickup.
// - No activation when rise above pickup was not preceded by idle.
// - Lingering between idle and pickup over 80 ms cancels activation.
// - Inrush needs cold load transition plus one phase second harmonic above threshold.
// - Second harmonic threshold zero makes inrush equal to cold load.
// - Inrush starts on rise; after first cycle kept only if harmonic present.
// - Both detection signals drive output and blocking matrix ports.
// - Cold load status: inactive, started, tripped on timeout.
// - Inrush status: inactive, started, tripped on timeout.
// - Largest phase magnitude compared to thresholds and readable.
// - Settings per mode current; primary scaled idle and pickup readable.
// - Settings writable only while a valid password is entered.
package cli_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CLI_OFF_CTRL     = 8'h00;
  localparam logic [7:0] CLI_OFF_HOLD     = 8'h04;
  localparam logic [7:0] CLI_OFF_IDLE     = 8'h08;
  localparam logic [7:0] CLI_OFF_PICKUP   = 8'h0C;
  localparam logic [7:0] CLI_OFF_F2       = 8'h10;
  localparam logic [7:0] CLI_OFF_STATUS   = 8'h14;
  localparam logic [7:0] CLI_OFF_IMAX     = 8'h18;
  localparam logic [7:0] CLI_OFF_IDLE_PRI = 8'h1C;
  localparam logic [7:0] CLI_OFF_PICK_PRI = 8'h20;
  localparam logic [7:0] CLI_OFF_IRQ_STAT = 8'h24;
  localparam logic [7:0] CLI_OFF_IRQ_EN   = 8'h28;
  localparam logic [7:0] CLI_OFF_IRQ_CLR  = 8'h2C;
  localparam logic [7:0] CLI_OFF_MODE_I   = 8'h30;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int         CLI_CTRL_PWD_BIT  = 0;
  localparam logic [31:0] CLI_PWD_KEY      = 32'h0000A5C3; // arbitrary unlock key
  localparam logic [15:0] CLI_RST_HOLD     = 16'h0064;     // units of ms
  localparam logic [15:0] CLI_RST_IDLE     = 16'h0010;     // 1/256 per mode current
  localparam logic [15:0] CLI_RST_PICKUP   = 16'h0140;
  localparam logic [7:0]  CLI_RST_F2       = 8'h14;        // percent
  localparam logic [15:0] CLI_RST_MODE_I   = 16'h0100;     // amperes
  localparam int          CLI_SCALE_SHIFT  = 8;
  localparam int          CLI_IRQ_W        = 4;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLI_CLK_MHZ        = 100;
  localparam int CLI_MS_CYCLES      = CLI_CLK_MHZ * 1000;
  localparam int CLI_TRANSITION_MS  = 80;
  localparam int CLI_FIRST_CYCLE_MS = 20;

  typedef enum logic [1:0] { CLI_ST_INACTIVE, CLI_ST_START, CLI_ST_TRIP } cli_status_t;

  typedef struct packed {
    logic [15:0] phase_a_current;
    logic [15:0] phase_b_current;
    logic [15:0] phase_c_current;
  } cli_phases_t;

  typedef struct packed {
    logic [7:0] ratio_a;
    logic [7:0] ratio_b;
    logic [7:0] ratio_c;
  } cli_ratios_t;

  typedef struct packed {
    logic [15:0] hold_ms;
    logic [15:0] idle_lvl;
    logic [15:0] pickup_lvl;
    logic [7:0]  second_harmonic_threshold;
  } cli_settings_t;
endpackage : cli_pkg

/* File: cli_ms_tick.sv */
// Purpose: Millisecond enable pulse divider.
// Assumes: ref_clk at the package rate.
// Notes: One-cycle pulse every CYCLES clocks.
module cli_ms_tick #(
  parameter int CYCLES = cli_pkg::CLI_MS_CYCLES
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Tick
  output logic      tick
);
  import cli_pkg::*;
  if (CYCLES < 2) begin : g_bad_cycles
    $error("cli_ms_tick: CYCLES too small");
  end
  logic [31:0] cnt_r;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 32'h00000000;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_r == 32'(CYCLES - 1));
      cnt_r <= (cnt_r == 32'(CYCLES - 1)) ? 32'h00000000 : cnt_r + 32'h00000001;
    end
  end
endmodule : cli_ms_tick

/* File: cli_max3.sv */
// Purpose: Largest of three phase magnitudes and harmonic ratio check.
// Assumes: Inputs on the ref_clk domain.
// Notes: Registered, one cycle of latency.
module cli_max3 (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  // Measurements
  input  wire cli_pkg::cli_phases_t phases,
  input  wire cli_pkg::cli_ratios_t ratios,
  input  wire logic [7:0]           f2_thr,
  // Results
  output logic [15:0]               imax,
  output logic                      f2_any
);
  import cli_pkg::*;
  wire [15:0] ab = (phases.phase_a_current > phases.phase_b_current) ?
                   phases.phase_a_current : phases.phase_b_current;
  wire [15:0] abc = (ab > phases.phase_c_current) ? ab : phases.phase_c_current;
  wire f2_hit = (ratios.ratio_a > f2_thr) || (ratios.ratio_b > f2_thr) ||
                (ratios.ratio_c > f2_thr);
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      imax   <= 16'h0000;
      f2_any <= 1'b0;
    end else begin
      imax   <= abc;
      f2_any <= f2_hit;
    end
  end
endmodule : cli_max3

/* File: cli_matrix_model.sv */
// Purpose: Stand-in for protection stages fed by the output and blocking matrices.
// Assumes: Detection sources are levels on ref_clk.
// Notes: Counts activations; a stage stays blocked while either source is high.
module cli_matrix_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Matrix sources
  input  wire logic cold_load_det,
  input  wire logic inrush_det,
  // Stage view
  output logic       stage_blocked,
  output logic [7:0] cold_cnt,
  output logic [7:0] inrush_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cold_r, inr_r;

  assign stage_blocked = cold_load_det | inrush_det;

  // Rising edges only, so a long hold counts once
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cold_r     <= 1'b0;
      inr_r      <= 1'b0;
      cold_cnt   <= 8'h00;
      inrush_cnt <= 8'h00;
    end else begin
      cold_r     <= cold_load_det;
      inr_r      <= inrush_det;
      cold_cnt   <= cold_cnt + 8'((cold_load_det & ~cold_r));
      inrush_cnt <= inrush_cnt + 8'((inrush_det & ~inr_r));
    end
  end
endmodule : cli_matrix_model

/* File: tb_top.sv */
// Purpose: Self-checking bench for the cold load and inrush detector.
// Assumes: MS_CYCLES of 10, so one ms lasts ten clocks.
// Notes: Phase levels come from an xorshift stream seeded at 94.
module tb_top;
  import cli_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic        ref_clk, resetn, meas_valid, stage_blocked;
  cli_phases_t phases;
  cli_ratios_t ratios;
  logic [7:0]  s_awaddr, s_araddr, cold_cnt, inrush_cnt;
  logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready;
  logic [31:0] s_wdata, s_rdata, rng, rd, exp_imax;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, rsp;
  logic        cold_load_det, inrush_det, irq;
  int          fails, checks_done, cyc;

  cli_detector #(.MS_CYCLES(10)) i_cli_detector (
    .ref_clk, .resetn, .meas_valid, .phases, .ratios,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
    .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready,
    .cold_load_det, .inrush_det, .irq
  );
  cli_matrix_model i_cli_matrix_model (
    .ref_clk, .resetn, .cold_load_det, .inrush_det, .stage_blocked, .cold_cnt, .inrush_cnt
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Strobe every other clock; cycle ceiling cuts a hang
  always @(posedge ref_clk) begin
    meas_valid <= resetn & ~meas_valid;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  function automatic logic [31:0] pri(input logic [15:0] s, input logic [15:0] m);
    return (32'(s) * 32'(m)) >> CLI_SCALE_SHIFT;
  endfunction : pri

  task automatic stop_test();
    if (fails == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (!aw && s_awready) begin
        aw = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w && s_wready) begin
        w = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk); while (!s_bvalid);
    chk("bresp", 32'h0, s_bresp);
  endtask : axw

  task automatic axr(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_arready);
    s_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_rvalid);
    rd = s_rdata;
    rsp = s_rresp;
  endtask : axr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    axr(a);
    chk($sformatf("reg %h", a), e, rd);
  endtask : rchk

  // Kind 0 all idle, 1 one phase between limits, 2 one phase above pickup
  task automatic drive(input int kind, input int n);
    logic [15:0] v[3];
    int k;
    k = int'(xs() % 3);
    for (int i = 0; i < 3; i++) v[i] = 16'(xs() % 16);
    if (kind == 1) v[k] = 16'h0080;
    if (kind == 2) v[k] = 16'h0141 + 16'(xs() % 256);
    phases <= {v[0], v[1], v[2]};
    exp_imax = 32'(v[k]);
    repeat (n) @(posedge ref_clk);
  endtask : drive
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    rng = 32'd94;
    {resetn, s_awvalid, s_wvalid, s_arvalid, s_awaddr, s_araddr, s_wdata} = '0;
    {phases, ratios} = '0;
    s_wstrb = 4'hF;
    s_bready = 1'b1;
    s_rready = 1'b1;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rchk(CLI_OFF_IDLE, 32'(CLI_RST_IDLE));
    rchk(CLI_OFF_PICKUP, 32'(CLI_RST_PICKUP));
    rchk(CLI_OFF_F2, 32'(CLI_RST_F2));
    rchk(CLI_OFF_IDLE_PRI, pri(CLI_RST_IDLE, CLI_RST_MODE_I));
    axr(8'h40);
    chk("rresp", 32'h2, rsp);
    axw(CLI_OFF_HOLD, 32'h5);
    rchk(CLI_OFF_HOLD, 32'(CLI_RST_HOLD));
    axw(CLI_OFF_CTRL, CLI_PWD_KEY);
    axw(CLI_OFF_HOLD, 32'h5);
    rchk(CLI_OFF_HOLD, 32'h5);
    axw(CLI_OFF_MODE_I, 32'h200);
    rchk(CLI_OFF_PICK_PRI, pri(CLI_RST_PICKUP, 16'h0200));
    axw(CLI_OFF_IRQ_EN, 32'h1);
    drive(0, 20);
    drive(2, 30);
    chk("cold", 1, cold_load_det);
    chk("blocked", 1, stage_blocked);
    chk("inrush", 1, inrush_det);
    chk("irq", 1, irq);
    rchk(CLI_OFF_STATUS, 32'h5);
    rchk(CLI_OFF_IMAX, exp_imax);
    repeat (300) @(posedge ref_clk);
    chk("cold", 1, cold_load_det);
    drive(1, 30);
    chk("cold", 0, cold_load_det);
    chk("blocked", 0, stage_blocked);
    rchk(CLI_OFF_STATUS, 32'hA);
    axw(CLI_OFF_IRQ_CLR, 32'h1);
    rchk(CLI_OFF_IRQ_STAT, 32'hE);
    chk("irq", 0, irq);
    axw(CLI_OFF_IRQ_CLR, 32'hF);
    drive(2, 60);
    chk("cold", 0, cold_load_det);
    drive(0, 20);
    drive(1, 900);
    drive(2, 60);
    chk("cold", 0, cold_load_det);
    drive(0, 20);
    drive(2, 100);
    chk("inrush", 1, inrush_det);
    repeat (250) @(posedge ref_clk);
    chk("inrush", 0, inrush_det);
    chk("cold", 1, cold_load_det);
    axw(CLI_OFF_F2, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk("inrush", 1, inrush_det);
    axw(CLI_OFF_F2, 32'(CLI_RST_F2));
    drive(0, 30);
    ratios <= {8'h1E, 8'h00, 8'h00};
    drive(2, 350);
    chk("inrush", 1, inrush_det);
    ratios <= '0;
    drive(0, 30);
    axw(CLI_OFF_F2, 32'h0);
    drive(2, 350);
    chk("inrush", 1, inrush_det);
    drive(0, 30);
    chk("inrush", 0, inrush_det);
    chk("cold cnt", 32'h4, cold_cnt);
    chk("inrush cnt", 32'h5, inrush_cnt);
    stop_test();
  end
endmodule : tb_top
